// [pkg/rvt_params.svh]
`ifndef RVT_PARAMS_SVH
`define RVT_PARAMS_SVH
// Behaviour
// - Reset bypasses interrupt logic, takes no vector
// - Any reset clears registers and program counter
// - Fetching starts at address zero after reset
// - Primary table: traps from 4, IRQs 14h-FEh
// - Alternate table from 100h, code at 200h
// - Lower vector address has higher natural priority
// - Select bit set uses alternate table entries
// - Entry holds 24-bit handler address loaded into PC

// ==========================================================
// Widths and counts
`define RVT_ADDR_W      24
`define RVT_IDX_W       7
`define RVT_NUM_TRAPS   8
`define RVT_NUM_IRQS    118
`define RVT_NUM_VEC     126

// ==========================================================
// Address map
`define RVT_RESET_ADDR  24'h00_0000
`define RVT_JUMP_TARGET 24'h00_0002
`define RVT_PRI_BASE    24'h00_0004
`define RVT_PRI_IRQ0    24'h00_0014
`define RVT_PRI_LAST    24'h00_00FE
`define RVT_ALT_TABLE   24'h00_0100
`define RVT_ALT_BASE    24'h00_0104
`define RVT_ALT_IRQ0    24'h00_0114
`define RVT_ALT_LAST    24'h00_01FE
`define RVT_CODE_START  24'h00_0200
`define RVT_INSN_STEP   24'h00_0002

`endif

// [pkg/rvt_pkg.sv]
`include "rvt_params.svh"

package rvt_pkg;

  // ========================================================
  // Types
  typedef logic [`RVT_ADDR_W-1:0] rvt_addr_t;
  typedef logic [`RVT_IDX_W-1:0]  rvt_idx_t;

  typedef enum logic [0:0] {
    RVT_ST_RUN,
    RVT_ST_VWAIT
  } rvt_state_e;

  typedef struct packed {
    logic      req;
    logic      is_vec;
    rvt_addr_t addr;
  } rvt_fetch_s;

  typedef struct packed {
    logic     ack;
    logic     alt;
    rvt_idx_t num;
  } rvt_take_s;

  // ========================================================
  // Vector location: base plus two per entry
  function automatic rvt_addr_t rvt_vec_loc(input logic     alt,
                                            input rvt_idx_t idx);
    rvt_addr_t base;
    base = alt ? `RVT_ALT_BASE : `RVT_PRI_BASE;
    return base + {16'h0000, idx, 1'b0};
  endfunction

endpackage

// [rtl/rvt_map.sv]
`timescale 1ns/1ps

module rvt_map
  import rvt_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     rst_b,
  input  wire logic                     alternate_table_select,
  input  wire logic [`RVT_NUM_TRAPS-1:0] trap_pend,
  input  wire logic [`RVT_NUM_IRQS-1:0]  irq_pend,
  input  wire logic                     fetch_next,
  input  wire logic [`RVT_ADDR_W-1:0]   mem_rdata,
  input  wire logic                     mem_rvalid,
  output rvt_fetch_s                    fetch_reg,
  output rvt_addr_t                     pc_reg,
  output rvt_take_s                     take_reg
);

  // ========================================================
  // Priority pick over traps then interrupts
  logic     pick_found;
  rvt_idx_t pick_idx;

  rvt_prio u_prio
  (
    .pend  ({irq_pend, trap_pend}),
    .found (pick_found),
    .idx   (pick_idx)
  );

  // ========================================================
  // Sequencer
  rvt_state_e state_reg;
  rvt_state_e state_next;
  rvt_addr_t  pc_next;
  rvt_fetch_s fetch_next_s;
  rvt_take_s  take_next;
  logic       alt_reg;
  logic       alt_next;

  // Vector entry is taken ahead of a pending advance; the CPU
  // replays the held instruction after the handler returns.
  always_comb
  begin
    state_next   = state_reg;
    pc_next      = pc_reg;
    fetch_next_s = fetch_reg;
    take_next    = take_reg;
    alt_next     = alt_reg;
    take_next.ack = 1'b0;
    unique case (state_reg)
      RVT_ST_RUN:
      begin
        if (pick_found)
        begin
          alt_next            = alternate_table_select;
          fetch_next_s.req    = 1'b1;
          fetch_next_s.is_vec = 1'b1;
          fetch_next_s.addr   = rvt_vec_loc(alternate_table_select,
                                            pick_idx);
          take_next.num       = pick_idx;
          take_next.alt       = alternate_table_select;
          state_next          = RVT_ST_VWAIT;
        end
        else if (fetch_next)
        begin
          pc_next           = pc_reg + `RVT_INSN_STEP;
          fetch_next_s.req  = 1'b1;
          fetch_next_s.addr = pc_reg + `RVT_INSN_STEP;
        end
      end
      RVT_ST_VWAIT:
      begin
        if (mem_rvalid)
        begin
          pc_next             = mem_rdata;
          fetch_next_s.is_vec = 1'b0;
          fetch_next_s.addr   = mem_rdata;
          take_next.ack       = 1'b1;
          state_next          = RVT_ST_RUN;
        end
      end
    endcase
  end

  // Reset forces everything to zero except the fetch request, which it raises to fetch from the start
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg        <= RVT_ST_RUN;
      pc_reg           <= `RVT_RESET_ADDR;
      fetch_reg.req    <= 1'b1;
      fetch_reg.is_vec <= 1'b0;
      fetch_reg.addr   <= `RVT_RESET_ADDR;
      take_reg         <= '0;
      alt_reg          <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      pc_reg    <= pc_next;
      fetch_reg <= fetch_next_s;
      take_reg  <= take_next;
      alt_reg   <= alt_next;
    end
  end

  // ========================================================
  // Checks
  sequence s_vec_issue;
    state_reg == RVT_ST_RUN && pick_found;
  endsequence

  sequence s_vec_done;
    state_reg == RVT_ST_VWAIT && mem_rvalid;
  endsequence

  property p_reset_start;
    @(posedge clk_sys) disable iff (!rst_b)
      !$past(rst_b) |-> pc_reg == `RVT_RESET_ADDR &&
        fetch_reg.addr == `RVT_RESET_ADDR && !fetch_reg.is_vec;
  endproperty
  a_reset_start: assert property (p_reset_start)
    else $error("Fetch did not start at zero after reset");

  property p_reset_no_vec;
    @(posedge clk_sys) disable iff (!rst_b)
      !$past(rst_b) |-> state_reg == RVT_ST_RUN && !take_reg.ack;
  endproperty
  a_reset_no_vec: assert property (p_reset_no_vec)
    else $error("Reset entry went through a vector");

  property p_pc_cleared;
    @(posedge clk_sys) disable iff (!rst_b)
      !$past(rst_b) |-> pc_reg == '0 && take_reg == '0;
  endproperty
  a_pc_cleared: assert property (p_pc_cleared)
    else $error("Registers not cleared by reset");

  property p_pri_range;
    @(posedge clk_sys) disable iff (!rst_b)
      s_vec_issue ##0 !alternate_table_select |=>
        fetch_reg.is_vec && fetch_reg.addr >= `RVT_PRI_BASE &&
        fetch_reg.addr <= `RVT_PRI_LAST &&
        (take_reg.num < 7'h08 || fetch_reg.addr >= `RVT_PRI_IRQ0);
  endproperty
  a_pri_range: assert property (p_pri_range)
    else $error("Primary vector fetched outside its table");

  property p_alt_range;
    @(posedge clk_sys) disable iff (!rst_b)
      s_vec_issue ##0 alternate_table_select |=>
        fetch_reg.addr >= `RVT_ALT_BASE &&
        fetch_reg.addr <= `RVT_ALT_LAST &&
        fetch_reg.addr < `RVT_CODE_START &&
        (take_reg.num < 7'h08 || fetch_reg.addr >= `RVT_ALT_IRQ0);
  endproperty
  a_alt_range: assert property (p_alt_range)
    else $error("Alternate vector fetched outside its table");

  property p_alt_follows;
    @(posedge clk_sys) disable iff (!rst_b)
      s_vec_issue |=> take_reg.alt == $past(alternate_table_select)
        && alt_reg == take_reg.alt;
  endproperty
  a_alt_follows: assert property (p_alt_follows)
    else $error("Table choice does not follow select bit");

  property p_loc_calc;
    @(posedge clk_sys) disable iff (!rst_b)
      s_vec_issue |=> fetch_reg.addr ==
        rvt_vec_loc($past(alternate_table_select), $past(pick_idx))
        ##1 state_reg == RVT_ST_VWAIT || take_reg.ack;
  endproperty
  a_loc_calc: assert property (p_loc_calc)
    else $error("Vector location is not base plus twice index");

  property p_load_pc;
    @(posedge clk_sys) disable iff (!rst_b)
      s_vec_done |=> take_reg.ack && pc_reg == $past(mem_rdata) &&
        fetch_reg.addr == $past(mem_rdata) && !fetch_reg.is_vec;
  endproperty
  a_load_pc: assert property (p_load_pc)
    else $error("Handler address not loaded into program counter");

  property p_lowest_taken;
    @(posedge clk_sys) disable iff (!rst_b)
      s_vec_issue ##0 trap_pend != '0 |=> take_reg.num < 7'h08;
  endproperty
  a_lowest_taken: assert property (p_lowest_taken)
    else $error("Interrupt taken ahead of a pending trap");

  property p_advance_step;
    @(posedge clk_sys) disable iff (!rst_b)
      state_reg == RVT_ST_RUN && !pick_found && fetch_next |=>
        pc_reg == $past(pc_reg) + `RVT_INSN_STEP &&
        fetch_reg.addr == pc_reg && !fetch_reg.is_vec;
  endproperty
  a_advance_step: assert property (p_advance_step)
    else $error("Advance did not step the fetch by one word");

  // A pending vector must win over an advance in the same cycle
  property p_vec_over_advance;
    @(posedge clk_sys) disable iff (!rst_b)
      s_vec_issue |=> pc_reg == $past(pc_reg) && fetch_reg.is_vec;
  endproperty
  a_vec_over_advance: assert property (p_vec_over_advance)
    else $error("Program counter moved while a vector was taken");

  property p_ack_pulse;
    @(posedge clk_sys) disable iff (!rst_b)
      take_reg.ack |=> !take_reg.ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("Handler load acknowledged for more than one cycle");

  property p_vwait_hold;
    @(posedge clk_sys) disable iff (!rst_b)
      state_reg == RVT_ST_VWAIT && !mem_rvalid |=>
        state_reg == RVT_ST_VWAIT && $stable(fetch_reg) && $stable(pc_reg);
  endproperty
  a_vwait_hold: assert property (p_vwait_hold)
    else $error("Vector fetch changed before the entry arrived");

  property p_req_high;
    @(posedge clk_sys) disable iff (!rst_b)
      fetch_reg.req;
  endproperty
  a_req_high: assert property (p_req_high)
    else $error("Fetch request dropped after reset");

endmodule

// [rtl/rvt_prio.sv]
`timescale 1ns/1ps

module rvt_prio
  import rvt_pkg::*;
(
  input  wire logic [`RVT_NUM_VEC-1:0] pend,
  output logic                         found,
  output rvt_idx_t                     idx
);

  // ========================================================
  // Lowest index wins; scan downward so the last hit is it
  always_comb
  begin
    found = 1'b0;
    idx   = '0;
    for (int i = `RVT_NUM_VEC - 1; i >= 0; i--)
    begin
      if (pend[i])
      begin
        found = 1'b1;
        idx   = 7'(i);
      end
    end
  end

  // ========================================================
  // Checks
  property p_lowest_wins;
    @(pend) found |-> pend[idx] &&
      ((pend & ((126'(1) << idx) - 126'(1))) == '0);
  endproperty
  a_lowest_wins: assert property (p_lowest_wins)
    else $error("Chosen vector is not the lowest pending");

endmodule

// [verification/rvt_mem_model.sv]
`timescale 1ns/1ps

// ==========================================================
// Program memory answering vector-entry reads
module rvt_mem_model
  import rvt_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire rvt_fetch_s fetch,
  input  wire logic [3:0] lat,
  output rvt_addr_t       mem_rdata,
  output logic            mem_rvalid
);
  logic       busy_reg;
  logic [3:0] cnt_reg;
  rvt_addr_t  loc_reg;

  // Every entry holds a distinct handler, so a wrong slot shows;
  // the first slot of each table (trap 0) points at the reset handler
  function automatic rvt_addr_t entry_val(input rvt_addr_t a);
    if (a[7:0] == 8'h04)
      return `RVT_CODE_START;
    return a ^ 24'h5A_0200;
  endfunction

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy_reg   <= 1'b0;
      cnt_reg    <= 4'h0;
      loc_reg    <= 24'h00_0000;
      mem_rvalid <= 1'b0;
      mem_rdata  <= 24'h00_0000;
    end
    else
    begin
      mem_rvalid <= 1'b0;
      // Stale data is inverted every cycle between answers
      mem_rdata  <= ~mem_rdata;
      if (busy_reg)
      begin
        if (cnt_reg == 4'h0)
        begin
          mem_rvalid <= 1'b1;
          mem_rdata  <= entry_val(loc_reg);
          busy_reg   <= 1'b0;
        end
        else
          cnt_reg <= cnt_reg - 4'h1;
      end
      else if (fetch.is_vec && !mem_rvalid)
      begin
        busy_reg <= 1'b1;
        loc_reg  <= fetch.addr;
        cnt_reg  <= lat;
      end
    end
  end
endmodule

// [verification/tb_reset_vector_table_map.sv]
`timescale 1ns/1ps

module tb_reset_vector_table_map
  import rvt_pkg::*;
;
  logic         clk_sys = 1'b0;
  logic         rst_b = 1'b0;
  logic         alt_sel = 1'b0;
  logic [125:0] pend = '0;
  logic         fetch_next = 1'b0;
  logic [3:0]   lat = 4'h0;
  rvt_addr_t    mem_rdata;
  logic         mem_rvalid;
  rvt_fetch_s   fetch;
  rvt_addr_t    pc;
  rvt_take_s    take;
  int           seed = 32'h944c;
  int           checks = 0;
  int           bad_count = 0;
  int           i;

  always #10 clk_sys = ~clk_sys;

  rvt_map u_dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .alternate_table_select(alt_sel), .trap_pend(pend[7:0]),
    .irq_pend(pend[125:8]), .fetch_next(fetch_next),
    .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
    .fetch_reg(fetch), .pc_reg(pc), .take_reg(take));

  rvt_mem_model u_mem (.clk_sys(clk_sys), .rst_b(rst_b), .fetch(fetch),
    .lat(lat), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));

  // ==========================================================
  // Helpers
  task automatic wrap_up();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input rvt_addr_t e, rvt_addr_t g);
    checks++;
    if (g !== e)
    begin
      $display("FAIL %s expected %h seen %h", what, e, g);
      bad_count++;
    end
  endtask

  task automatic give_up(input string what);
    $display("FAIL %s expected done seen timeout", what);
    bad_count++;
    wrap_up();
  endtask

  function automatic rvt_addr_t loc(input logic alt, input int k);
    return (alt ? `RVT_ALT_BASE : `RVT_PRI_BASE) + rvt_addr_t'(2 * k);
  endfunction

  // First slot (trap 0) points at the default reset handler
  function automatic rvt_addr_t handler(input logic alt, input int k);
    if (k == 0)
      return `RVT_CODE_START;
    return loc(alt, k) ^ 24'h5A_0200;
  endfunction

  function automatic int rnd(input int m);
    return (($random(seed)) & 32'h7FFF_FFFF) % m;
  endfunction

  task automatic advance(input int cnt);
    rvt_addr_t p;
    p = pc;
    fetch_next = 1'b1;
    repeat (cnt) @(negedge clk_sys);
    fetch_next = 1'b0;
    chk("advance pc", p + rvt_addr_t'(2 * cnt), pc);
    chk("advance fetch", p + rvt_addr_t'(2 * cnt), fetch.addr);
    @(negedge clk_sys);
  endtask

  // One or two pending sources at once (a equal to b gives one); the lower entry must win
  task automatic take_one(input int a, input int b, input logic alt,
                          input logic [3:0] l);
    int           n;
    int           k;
    logic [125:0] want;
    k = (a < b) ? a : b;
    want = '0;
    want[a] = 1'b1;
    want[b] = 1'b1;
    alt_sel = alt;
    lat = l;
    pend = want;
    for (n = 0; n < 20 && fetch.is_vec !== 1'b1; n++) @(negedge clk_sys);
    if (fetch.is_vec !== 1'b1) give_up("vector issue");
    chk("vector loc", loc(alt, k), fetch.addr);
    for (n = 0; n < 40 && take.ack !== 1'b1; n++) @(negedge clk_sys);
    if (take.ack !== 1'b1) give_up("handler load");
    chk("handler pc", handler(alt, k), pc);
    chk("handler fetch", handler(alt, k), fetch.addr);
    chk("entry num", rvt_addr_t'(k), rvt_addr_t'(take.num));
    chk("table alt", rvt_addr_t'(alt), rvt_addr_t'(take.alt));
    pend = '0;
    // Let an edge pass so the next request starts from a clean level
    @(negedge clk_sys);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (2) @(negedge clk_sys);
    chk("reset pc", 24'h00_0000, pc);
    chk("reset req", 24'h00_0001, rvt_addr_t'(fetch.req));
    chk("reset vec", 24'h00_0000, rvt_addr_t'(fetch.is_vec));
    chk("reset ack", 24'h00_0000, rvt_addr_t'(take.ack));
    rst_b = 1'b1;
    @(negedge clk_sys);
    chk("first fetch", `RVT_RESET_ADDR, fetch.addr);
    advance(1);
    chk("jump target word", `RVT_JUMP_TARGET, fetch.addr);
    advance(2);
    take_one(0, 0, 1'b0, 4'h0);
    take_one(7, 7, 1'b1, 4'h3);
    take_one(8, 8, 1'b0, 4'h1);
    take_one(125, 125, 1'b1, 4'h0);
    take_one(125, 124, 1'b0, 4'h2);
    take_one(9, 3, 1'b1, 4'h5);
    for (i = 0; i < 40; i++)
    begin
      advance(1 + rnd(8));
      take_one(rnd(126), rnd(126), rnd(2) == 1, 4'(rnd(16)));
    end
    // Reset in the middle of a vector fetch
    pend[50] = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst_b = 1'b0;
    #1;
    chk("mid reset pc", 24'h00_0000, pc);
    chk("mid reset vec", 24'h00_0000, rvt_addr_t'(fetch.is_vec));
    pend = '0;
    @(negedge clk_sys);
    rst_b = 1'b1;
    @(negedge clk_sys);
    chk("restart fetch", `RVT_RESET_ADDR, fetch.addr);
    wrap_up();
  end
endmodule
